// File: design/timer_pkg.sv
package timer_pkg;

    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned BYTE_W = 8;

    // Register indices; the byte address on the bus is four times the index
    localparam logic [7:0] IDX_CTRL = 8'h88;
    localparam logic [7:0] IDX_MODE = 8'h89;
    localparam logic [7:0] IDX_T0_LOW = 8'h8A;
    localparam logic [7:0] IDX_T1_LOW = 8'h8B;
    localparam logic [7:0] IDX_T0_HIGH = 8'h8C;
    localparam logic [7:0] IDX_T1_HIGH = 8'h8D;
    localparam logic [7:0] IDX_CLK_CTRL = 8'h8E;
    localparam logic [7:0] IDX_IRQ_CFG = 8'h8F;

    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] BYTE_MAX = 8'hFF;
    localparam logic [4:0] LOW5_MAX = 5'h1F;
    localparam logic [7:0] BYTE_ONE = 8'h01;
    localparam logic [4:0] LOW5_ONE = 5'h01;

    // Field positions inside the clock control and irq config registers
    localparam int unsigned CK_T0_BIT = 0;
    localparam int unsigned CK_T1_BIT = 1;
    localparam int unsigned PL0_BIT = 0;
    localparam int unsigned PL1_BIT = 1;
    localparam logic [7:0] CK_MASK = 8'h03;
    localparam logic [7:0] PL_MASK = 8'h03;

    localparam int unsigned PRESCALE_DIV_DEF = 12;

    typedef enum logic [1:0] {
        MODE_13 = 2'h0,
        MODE_16 = 2'h1,
        MODE_RELOAD = 2'h2,
        MODE_SPLIT = 2'h3
    } timer_mode_t;

    typedef struct packed {
        logic gate;
        logic counter_sel;
        timer_mode_t mode;
    } timer_cfg_t;

    typedef struct packed {
        timer_cfg_t one;
        timer_cfg_t zero;
    } mode_reg_t;

    typedef struct packed {
        logic tf1;
        logic tr1;
        logic tf0;
        logic tr0;
        logic [3:0] rsvd;
    } ctrl_reg_t;

    typedef struct packed {
        logic ovf;
        logic [7:0] hi;
        logic [7:0] lo;
    } count_t;

endpackage

// File: design/pin_edge_sync.sv
`timescale 1ns/1ps
module pin_edge_sync #(
    parameter int unsigned W = 4
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level,
    output logic [W-1:0] fall
);

    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;
    logic [W-1:0] prev_r;

    // Edge compares two settled stages, never the first one
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            meta_r <= '1;
            sync_r <= '1;
            prev_r <= '1;
        end else begin
            meta_r <= pin_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign level = sync_r;
    assign fall = prev_r & ~sync_r;

endmodule

// File: design/prescale_div.sv
`timescale 1ns/1ps
module prescale_div #(
    parameter int unsigned DIV = 12
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    output logic tick
);

    localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic tick_r;
    logic tick_nxt;

    always_comb begin
        tick_nxt = (cnt_r == LAST);
        cnt_nxt = tick_nxt ? '0 : cnt_r + CW'(1);
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt_r <= '0;
            tick_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;

endmodule

// File: design/dual_timer.sv
`timescale 1ns/1ps
// How it works
// - Gate clear: timer one counts whenever its run bit is set.
// - Gate set: timer one also needs external irq one at its chosen polarity.
// - Select clear: timer one counts the internal clock chosen in clock control.
// - Select set: timer one counts falling edges on its count pin.
// - Timer one mode 00 is 13-bit, 01 is 16-bit, 11 stops it.
// - Timer one mode 10 is the 8-bit auto-reload mode.
// - Gate clear: timer zero counts whenever its run bit is set.
// - Gate set: timer zero also needs external irq zero at its chosen polarity.
// - Select clear: timer zero counts the internal clock chosen in clock control.
// - Select set: timer zero counts falling edges on its count pin.
// - Timer zero modes: 13-bit, 16-bit, 8-bit reload, two split 8-bit timers.
// - Timer zero low byte is software readable and writable.
// - Timer one low byte is software readable and writable.
// - Timer zero high byte is software readable and writable.
// - Reload mode: low byte wrap sets overflow flag, reloads from high byte.
// - Timer one reload mode uses its own low and high bytes likewise.
// - Split: high byte times internal clock, gated by run one, sets flag one.
// - During split, timer one ignores its pin and never sets flag one.
module dual_timer #(
    parameter int unsigned PRESCALE_DIV = timer_pkg::PRESCALE_DIV_DEF
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [timer_pkg::ADDR_W-1:0] paddr,
    input wire logic [timer_pkg::DATA_W-1:0] pwdata,
    output logic [timer_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic timer_zero_count_pin,
    input wire logic timer_one_count_pin,
    input wire logic ext_irq_zero_input,
    input wire logic ext_irq_one_input,
    output logic timer_zero_overflow_pulse,
    output logic timer_one_overflow_pulse
);

    logic [3:0] pin_lvl;
    logic [3:0] pin_fall;
    logic pre_tick;

    timer_pkg::mode_reg_t mode_r;
    timer_pkg::mode_reg_t mode_nxt;
    timer_pkg::ctrl_reg_t ctrl_r;
    timer_pkg::ctrl_reg_t ctrl_nxt;
    logic [7:0] t0l_r;
    logic [7:0] t0l_nxt;
    logic [7:0] t0h_r;
    logic [7:0] t0h_nxt;
    logic [7:0] t1l_r;
    logic [7:0] t1l_nxt;
    logic [7:0] t1h_r;
    logic [7:0] t1h_nxt;
    logic [7:0] ckctl_r;
    logic [7:0] ckctl_nxt;
    logic [7:0] irqcfg_r;
    logic [7:0] irqcfg_nxt;
    logic [timer_pkg::DATA_W-1:0] prdata_r;
    logic [timer_pkg::DATA_W-1:0] prdata_nxt;
    logic pready_r;
    logic pready_nxt;
    logic pslverr_r;
    logic pslverr_nxt;
    logic ovf0_r;
    logic ovf0_nxt;
    logic ovf1_r;
    logic ovf1_nxt;

    logic split;
    logic tick0;
    logic tick1;
    logic th_tick;
    logic set_tf0;
    logic set_tf1;
    logic wr_en;
    logic mapped;
    logic [7:0] rd_byte;
    timer_pkg::count_t st0;
    timer_pkg::count_t st1;
    timer_pkg::count_t sth;

    // Pin order: irq one, irq zero, count one, count zero
    pin_edge_sync #(
        .W(4)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin_in({ext_irq_one_input, ext_irq_zero_input, timer_one_count_pin, timer_zero_count_pin}),
        .level(pin_lvl),
        .fall(pin_fall)
    );

    prescale_div #(
        .DIV(PRESCALE_DIV)
    ) u_div (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .tick(pre_tick)
    );

    function automatic logic hit(input logic [timer_pkg::ADDR_W-1:0] a, input logic [7:0] idx);
        hit = (a[timer_pkg::ADDR_W-1:2] == (timer_pkg::ADDR_W-2)'(idx));
    endfunction

    // Run bit, optionally qualified by the irq pin at its polarity
    function automatic logic gate_ok(input logic gate, input logic run, input logic lvl, input logic pol);
        gate_ok = run & (~gate | (lvl == pol));
    endfunction

    // Pin edge in counter mode, else system clock or prescaled enable
    function automatic logic src(input logic ct, input logic fall, input logic ck, input logic pre);
        src = ct ? fall : (ck | pre);
    endfunction

    // One increment of a timer in the given mode
    function automatic timer_pkg::count_t step(input timer_pkg::timer_mode_t m, input logic [7:0] hi,
                                                input logic [7:0] lo);
        timer_pkg::count_t r;
        r.ovf = 1'b0;
        r.hi = hi;
        r.lo = lo;
        unique case (m)
            timer_pkg::MODE_13: begin
                // Upper three low-byte bits are left alone
                r.lo[4:0] = lo[4:0] + timer_pkg::LOW5_ONE;
                if (lo[4:0] == timer_pkg::LOW5_MAX) begin
                    r.hi = hi + timer_pkg::BYTE_ONE;
                    r.ovf = (hi == timer_pkg::BYTE_MAX);
                end
            end
            timer_pkg::MODE_16: begin
                r.lo = lo + timer_pkg::BYTE_ONE;
                if (lo == timer_pkg::BYTE_MAX) begin
                    r.hi = hi + timer_pkg::BYTE_ONE;
                    r.ovf = (hi == timer_pkg::BYTE_MAX);
                end
            end
            timer_pkg::MODE_RELOAD: begin
                if (lo == timer_pkg::BYTE_MAX) begin
                    r.lo = hi;
                    r.ovf = 1'b1;
                end else begin
                    r.lo = lo + timer_pkg::BYTE_ONE;
                end
            end
            timer_pkg::MODE_SPLIT: begin
                r.lo = lo + timer_pkg::BYTE_ONE;
                r.ovf = (lo == timer_pkg::BYTE_MAX);
            end
        endcase
        step = r;
    endfunction

    always_comb begin
        split = (mode_r.zero.mode == timer_pkg::MODE_SPLIT);
        tick0 = gate_ok(mode_r.zero.gate, ctrl_r.tr0, pin_lvl[2], irqcfg_r[timer_pkg::PL0_BIT])
              & src(mode_r.zero.counter_sel, pin_fall[0], ckctl_r[timer_pkg::CK_T0_BIT], pre_tick);
        st0 = step(mode_r.zero.mode, t0h_r, t0l_r);
        th_tick = split & ctrl_r.tr1 & (ckctl_r[timer_pkg::CK_T0_BIT] | pre_tick);
        sth = step(timer_pkg::MODE_SPLIT, timer_pkg::RESET_BYTE, t0h_r);
        if (split) begin
            // Run one is taken by the high byte, so timer one runs on its mode alone
            tick1 = (mode_r.one.mode != timer_pkg::MODE_SPLIT)
                  & (ckctl_r[timer_pkg::CK_T1_BIT] | pre_tick);
        end else begin
            tick1 = (mode_r.one.mode != timer_pkg::MODE_SPLIT)
                  & gate_ok(mode_r.one.gate, ctrl_r.tr1, pin_lvl[3], irqcfg_r[timer_pkg::PL1_BIT])
                  & src(mode_r.one.counter_sel, pin_fall[1], ckctl_r[timer_pkg::CK_T1_BIT], pre_tick);
        end
        st1 = step(mode_r.one.mode, t1h_r, t1l_r);
        set_tf0 = tick0 & st0.ovf;
        set_tf1 = (th_tick & sth.ovf) | (tick1 & st1.ovf & ~split);
    end

    always_comb begin
        mapped = hit(paddr, timer_pkg::IDX_CTRL) | hit(paddr, timer_pkg::IDX_MODE)
               | hit(paddr, timer_pkg::IDX_T0_LOW) | hit(paddr, timer_pkg::IDX_T1_LOW)
               | hit(paddr, timer_pkg::IDX_T0_HIGH) | hit(paddr, timer_pkg::IDX_T1_HIGH)
               | hit(paddr, timer_pkg::IDX_CLK_CTRL) | hit(paddr, timer_pkg::IDX_IRQ_CFG);
        rd_byte = timer_pkg::RESET_BYTE;
        if (hit(paddr, timer_pkg::IDX_CTRL)) begin
            rd_byte = {ctrl_r.tf1, ctrl_r.tr1, ctrl_r.tf0, ctrl_r.tr0, 4'h0};
        end
        if (hit(paddr, timer_pkg::IDX_MODE)) begin
            rd_byte = mode_r;
        end
        if (hit(paddr, timer_pkg::IDX_T0_LOW)) begin
            rd_byte = t0l_r;
        end
        if (hit(paddr, timer_pkg::IDX_T1_LOW)) begin
            rd_byte = t1l_r;
        end
        if (hit(paddr, timer_pkg::IDX_T0_HIGH)) begin
            rd_byte = t0h_r;
        end
        if (hit(paddr, timer_pkg::IDX_T1_HIGH)) begin
            rd_byte = t1h_r;
        end
        if (hit(paddr, timer_pkg::IDX_CLK_CTRL)) begin
            rd_byte = ckctl_r;
        end
        if (hit(paddr, timer_pkg::IDX_IRQ_CFG)) begin
            rd_byte = irqcfg_r;
        end
    end

    always_comb begin
        // Answer is ready in the first access cycle: zero wait states
        pready_nxt = psel & ~penable & ~pready_r;
        pslverr_nxt = pready_r ? 1'b0 : (psel & ~penable & ~mapped);
        prdata_nxt = prdata_r;
        if (psel & ~penable) begin
            prdata_nxt = (~pwrite & mapped) ? {24'h000000, rd_byte} : 32'h00000000;
        end
        wr_en = psel & penable & pready_r & pwrite;

        mode_nxt = mode_r;
        ctrl_nxt = ctrl_r;
        t0l_nxt = t0l_r;
        t0h_nxt = t0h_r;
        t1l_nxt = t1l_r;
        t1h_nxt = t1h_r;
        ckctl_nxt = ckctl_r;
        irqcfg_nxt = irqcfg_r;

        if (tick0) begin
            t0l_nxt = st0.lo;
            if (!split) begin
                t0h_nxt = st0.hi;
            end
        end
        if (th_tick) begin
            t0h_nxt = sth.lo;
        end
        if (tick1) begin
            t1l_nxt = st1.lo;
            t1h_nxt = st1.hi;
        end

        // A software write to a count byte overrides the same-cycle increment
        if (wr_en) begin
            if (hit(paddr, timer_pkg::IDX_CTRL)) begin
                ctrl_nxt.tf1 = pwdata[7];
                ctrl_nxt.tr1 = pwdata[6];
                ctrl_nxt.tf0 = pwdata[5];
                ctrl_nxt.tr0 = pwdata[4];
            end
            if (hit(paddr, timer_pkg::IDX_MODE)) begin
                mode_nxt = pwdata[7:0];
            end
            if (hit(paddr, timer_pkg::IDX_T0_LOW)) begin
                t0l_nxt = pwdata[7:0];
            end
            if (hit(paddr, timer_pkg::IDX_T1_LOW)) begin
                t1l_nxt = pwdata[7:0];
            end
            if (hit(paddr, timer_pkg::IDX_T0_HIGH)) begin
                t0h_nxt = pwdata[7:0];
            end
            if (hit(paddr, timer_pkg::IDX_T1_HIGH)) begin
                t1h_nxt = pwdata[7:0];
            end
            if (hit(paddr, timer_pkg::IDX_CLK_CTRL)) begin
                ckctl_nxt = pwdata[7:0] & timer_pkg::CK_MASK;
            end
            if (hit(paddr, timer_pkg::IDX_IRQ_CFG)) begin
                irqcfg_nxt = pwdata[7:0] & timer_pkg::PL_MASK;
            end
        end

        // Hardware set wins over a clear in the same cycle
        ctrl_nxt.tf0 = ctrl_nxt.tf0 | set_tf0;
        ctrl_nxt.tf1 = ctrl_nxt.tf1 | set_tf1;
        ctrl_nxt.rsvd = 4'h0;

        ovf0_nxt = set_tf0;
        // Still offered to other blocks during split
        ovf1_nxt = (tick1 & st1.ovf) | (th_tick & sth.ovf);
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mode_r <= timer_pkg::RESET_BYTE;
            ctrl_r <= timer_pkg::RESET_BYTE;
            t0l_r <= timer_pkg::RESET_BYTE;
            t0h_r <= timer_pkg::RESET_BYTE;
            t1l_r <= timer_pkg::RESET_BYTE;
            t1h_r <= timer_pkg::RESET_BYTE;
            ckctl_r <= timer_pkg::RESET_BYTE;
            irqcfg_r <= timer_pkg::RESET_BYTE;
            prdata_r <= '0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            ovf0_r <= 1'b0;
            ovf1_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            ctrl_r <= ctrl_nxt;
            t0l_r <= t0l_nxt;
            t0h_r <= t0h_nxt;
            t1l_r <= t1l_nxt;
            t1h_r <= t1h_nxt;
            ckctl_r <= ckctl_nxt;
            irqcfg_r <= irqcfg_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            ovf0_r <= ovf0_nxt;
            ovf1_r <= ovf1_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign timer_zero_overflow_pulse = ovf0_r;
    assign timer_one_overflow_pulse = ovf1_r;

endmodule

// File: tb/pin_model.sv
`timescale 1ns/1ps
module pin_model (
    input wire logic ref_clk,
    output logic [1:0] pins
);
    initial begin
        pins = 2'h3;
    end
    // Three cycles low, three high: keeps the two-cycle minimum each way
    task automatic pulse(input int i, input int n);
        repeat (n) begin
            pins[i] <= 1'b0;
            repeat (3) @(posedge ref_clk);
            pins[i] <= 1'b1;
            repeat (3) @(posedge ref_clk);
        end
    endtask
endmodule

// File: tb/dual_timer_sva.sv
`timescale 1ns/1ps
module dual_timer_sva (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [timer_pkg::ADDR_W-1:0] paddr,
    input wire logic [timer_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic timer_zero_overflow_pulse,
    input wire logic timer_one_overflow_pulse
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Mapped indices 0x88 to 0x8F share the upper address bits
    property p_ready_after_setup;
        psel && !penable |=> pready;
    endproperty
    a_ready_after_setup: assert property (p_ready_after_setup) else $error("ready late");
    property p_ready_in_access;
        pready |-> psel && penable;
    endproperty
    a_ready_in_access: assert property (p_ready_in_access) else $error("ready outside access");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready stuck");
    property p_err_unmapped;
        psel && !penable && paddr[11:5] != 7'h11 |=> pslverr && prdata == 32'h0;
    endproperty
    a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped not refused");
    property p_no_err_mapped;
        psel && !penable && paddr[11:5] == 7'h11 |=> !pslverr;
    endproperty
    a_no_err_mapped: assert property (p_no_err_mapped) else $error("mapped refused");
    property p_err_with_ready;
        pslverr |-> pready;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
    property p_upper_zero;
        pready |-> prdata[31:8] == 24'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
    property p_reset_quiet;
        disable iff (1'b0) !rst_n |=> !pready && !timer_zero_overflow_pulse && !timer_one_overflow_pulse
            && prdata == 32'h0;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active in reset");
    c_write: cover property (pready && pwrite);
    c_err: cover property (pslverr);
    c_ovf0: cover property (timer_zero_overflow_pulse);
    c_ovf1: cover property (timer_one_overflow_pulse);
endmodule
bind dual_timer dual_timer_sva sva_u (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
    .pslverr, .timer_zero_overflow_pulse, .timer_one_overflow_pulse);

// File: tb/dual_timer_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module dual_timer_tb;
    localparam int unsigned DIV = 2;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [timer_pkg::ADDR_W-1:0] paddr = 12'h000;
    logic [timer_pkg::DATA_W-1:0] pwdata = 32'h00000000;
    logic [1:0] irq = 2'h0;
    wire logic [timer_pkg::DATA_W-1:0] prdata;
    wire logic pready;
    wire logic pslverr;
    wire logic [1:0] ovf;
    wire logic [1:0] pins;
    int failures = 0;
    int checks = 0;
    dual_timer #(.PRESCALE_DIV(DIV)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_zero_count_pin(pins[0]), .timer_one_count_pin(pins[1]), .ext_irq_zero_input(irq[0]),
        .ext_irq_one_input(irq[1]), .timer_zero_overflow_pulse(ovf[0]), .timer_one_overflow_pulse(ovf[1]));
    pin_model pin_u (.ref_clk(ref_clk), .pins(pins));
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic complete_run;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic give_up;
        `CHK(1'b0, 1'b1)
        complete_run();
    endtask
    // Waits on pready only; a slow answer is fine up to the bound
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q,
                       output logic e);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h000000, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) give_up();
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] q;
        logic e;
        apb(1'b1, idx, d, q, e);
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] q;
        logic e;
        apb(1'b0, idx, 8'h00, q, e);
        `CHK(q, exp)
        `CHK(e, 1'b0)
    endtask
    // Cycles between two successive overflow pulses of one timer
    task automatic period(input int w, input int lim, output int n);
        int k;
        k = 0;
        n = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (ovf[w] !== 1'b1 && k < lim);
        do begin
            @(posedge ref_clk);
            n++;
        end while (ovf[w] !== 1'b1 && n < lim);
        if (k >= lim || n >= lim) give_up();
    endtask
    task automatic t_regs;
        logic [7:0] q;
        logic e;
        for (int i = 0; i < 4; i++) begin
            rd_chk(8'(timer_pkg::IDX_MODE + i), 8'h00);
            wr(8'(timer_pkg::IDX_MODE + i), 8'(8'hA5 ^ i));
            rd_chk(8'(timer_pkg::IDX_MODE + i), 8'(8'hA5 ^ i));
        end
        apb(1'b0, 8'h90, 8'h00, q, e);
        `CHK({e, q}, 9'h100)
        $display("test regs done");
    endtask
    task automatic t_gate;
        logic [7:0] v;
        logic [7:0] v2;
        logic [7:0] lo_idx;
        for (int i = 0; i < 2; i++) begin
            lo_idx = 8'(timer_pkg::IDX_T0_LOW + i);
            wr(timer_pkg::IDX_CTRL, 8'h00);
            wr(timer_pkg::IDX_IRQ_CFG, 8'h01);
            wr(lo_idx, 8'h00);
            wr(timer_pkg::IDX_MODE, 8'h09 << (4 * i));
            irq[i] <= i[0];
            wr(timer_pkg::IDX_CTRL, 8'h10 << (2 * i));
            repeat (10) @(posedge ref_clk);
            rd_chk(lo_idx, 8'h00);
            irq[i] <= ~i[0];
            repeat (10) @(posedge ref_clk);
            apb(1'b0, lo_idx, 8'h00, v, v2[0]);
            `CHK(v > 8'h08, 1'b1)
            irq[i] <= i[0];
            wr(timer_pkg::IDX_MODE, 8'h01 << (4 * i));
            apb(1'b0, lo_idx, 8'h00, v, v2[0]);
            apb(1'b0, lo_idx, 8'h00, v2, v2[0]);
            `CHK(v2 != v, 1'b1)
        end
        $display("test gate done");
    endtask
    task automatic t_counter;
        wr(timer_pkg::IDX_CTRL, 8'h00);
        wr(timer_pkg::IDX_MODE, 8'h55);
        wr(timer_pkg::IDX_T0_LOW, 8'h00);
        wr(timer_pkg::IDX_T1_LOW, 8'h00);
        wr(timer_pkg::IDX_CTRL, 8'h50);
        fork
            pin_u.pulse(0, 5);
            pin_u.pulse(1, 3);
        join
        repeat (8) @(posedge ref_clk);
        rd_chk(timer_pkg::IDX_T0_LOW, 8'h05);
        rd_chk(timer_pkg::IDX_T1_LOW, 8'h03);
        $display("test counter done");
    endtask
    task automatic t_reload;
        int n;
        wr(timer_pkg::IDX_CTRL, 8'h00);
        wr(timer_pkg::IDX_MODE, 8'h22);
        wr(timer_pkg::IDX_T0_HIGH, 8'hF0);
        wr(timer_pkg::IDX_T1_HIGH, 8'hF8);
        // Start values equal to the reload so the first wrap comes within the wait bound
        wr(timer_pkg::IDX_T0_LOW, 8'hF0);
        wr(timer_pkg::IDX_T1_LOW, 8'hF8);
        wr(timer_pkg::IDX_CTRL, 8'h50);
        for (int c = 3; c >= 0; c -= 3) begin
            wr(timer_pkg::IDX_CLK_CTRL, c[7:0]);
            period(0, 200, n);
            `CHK(n, (c == 3) ? 16 : 16 * DIV)
            period(1, 200, n);
            `CHK(n, (c == 3) ? 8 : 8 * DIV)
        end
        rd_chk(timer_pkg::IDX_CTRL, 8'hF0);
        wr(timer_pkg::IDX_CTRL, 8'h00);
        rd_chk(timer_pkg::IDX_T0_HIGH, 8'hF0);
        $display("test reload done");
    endtask
    task automatic t_mode13;
        int n;
        wr(timer_pkg::IDX_CLK_CTRL, 8'h03);
        wr(timer_pkg::IDX_MODE, 8'h30);
        wr(timer_pkg::IDX_T0_HIGH, 8'hFF);
        wr(timer_pkg::IDX_T0_LOW, 8'h1C);
        wr(timer_pkg::IDX_T1_LOW, 8'h00);
        wr(timer_pkg::IDX_CTRL, 8'h50);
        period(0, 9000, n);
        `CHK(n, 8192)
        rd_chk(timer_pkg::IDX_T1_LOW, 8'h00);
        $display("test mode13 done");
    endtask
    task automatic t_split;
        int n;
        logic [7:0] v;
        logic e;
        wr(timer_pkg::IDX_CTRL, 8'h00);
        wr(timer_pkg::IDX_MODE, 8'h53);
        wr(timer_pkg::IDX_T0_LOW, 8'h00);
        wr(timer_pkg::IDX_T1_LOW, 8'h00);
        wr(timer_pkg::IDX_T1_HIGH, 8'h00);
        wr(timer_pkg::IDX_T0_HIGH, 8'hFC);
        wr(timer_pkg::IDX_CTRL, 8'h40);
        period(1, 400, n);
        `CHK(n, 256)
        rd_chk(timer_pkg::IDX_CTRL, 8'hC0);
        rd_chk(timer_pkg::IDX_T0_LOW, 8'h00);
        // Pin one stays idle, so only the system clock can have moved timer one
        apb(1'b0, timer_pkg::IDX_T1_LOW, 8'h00, v, e);
        `CHK(v != 8'h00, 1'b1)
        $display("test split done");
    endtask
    initial begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_regs();
        wr(timer_pkg::IDX_CLK_CTRL, 8'h03);
        t_gate();
        t_counter();
        t_reload();
        t_mode13();
        t_split();
        complete_run();
    end
endmodule
